// file: watchdog_reset_timer_test.sv
// self-checking bench of the watchdog reset timer: register access, free-running
// count, software reset pulse, halt freeze and wake, reset state
// assumes wdt_core with a one-cycle wishbone answer and options driven here
`timescale 1ns/1ps
`include "wdt_defines.svh"

module watchdog_reset_timer_test;
    import wdt_pkg::*;

    logic        clk_i;           // core clock
    logic        rst_i;           // synchronous reset
    wdt_wb_req_t wb_req;          // bus request
    wdt_wb_rsp_t wb_rsp;          // bus answer
    logic        wait_i;          // cpu wait level
    logic        halt_i;          // halt instruction pulse
    logic        ext_irq_i;       // wake interrupt
    logic        rst_n_o;         // reset pin
    logic        halted_o;        // frozen flag
    int          fail_count;      // mismatches
    int          samples_checked; // comparisons
    int          cycles;          // timeout counter
    logic [31:0] rd;              // read data
    logic        er;              // error seen
    logic [7:0]  v;               // random control value
    int          n;               // pulse length
    logic        hw_opt;          // hardware option level
    logic        hr_opt;          // reset-on-halt option level

    wdt_core dut_u (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wb_req_i   (wb_req),
        .wb_rsp_o   (wb_rsp),
        .hw_wdt_i   (hw_opt),
        .halt_rst_i (hr_opt),
        .wait_i     (wait_i),
        .halt_i     (halt_i),
        .ext_irq_i  (ext_irq_i),
        .rst_n_o    (rst_n_o),
        .halted_o   (halted_o)
    );

    // free-running clock, 20 ns period
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and run end
    task automatic end_of_test();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // compare one value, report a mismatch
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one classic wishbone cycle, waits for ack or err
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
        do @(posedge clk_i); while (!(wb_rsp.ack === 1'b1 || wb_rsp.err === 1'b1));
        q = wb_rsp.dat;
        e = wb_rsp.err;
        wb_req <= '0;
    endtask : bus

    // expected control readback after a write: active only ORed in
    function automatic logic [31:0] exp_ctrl(input logic act, input logic [7:0] wr);
        exp_ctrl = {24'h0, act | wr[7], wr[6:0]};
    endfunction : exp_ctrl

    // wait n clock edges
    task automatic idle(input int cnt);
        repeat (cnt) @(posedge clk_i);
    endtask : idle

    // reset for 16 cycles
    task automatic do_reset();
        rst_i <= 1'b1;
        idle(16);
        rst_i <= 1'b0;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard: about 104k cycles expected
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 110000) begin
            fail_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        fail_count = 0;
        samples_checked = 0;
        cycles = 0;
        rst_i = 1'b1;
        wb_req = '0;
        wait_i = 1'b0;
        halt_i = 1'b0;
        ext_irq_i = 1'b0;
        hw_opt = 1'b0;
        hr_opt = 1'b0;
        void'($urandom(20));
        do_reset();
        // reset state and bus refusal
        bus(1'b0, `WDT_CTRL_OFFSET, 32'h0, rd, er);
        chk("ctrl after reset", rd, 32'h0000_007f);
        bus(1'b0, 8'h20, 32'h0, rd, er);
        chk("unmapped err", {31'h0, er}, 32'h1);
        // one step while inactive, then no reset
        idle(49200);
        bus(1'b0, `WDT_CTRL_OFFSET, 32'h0, rd, er);
        chk("count stepped", rd, 32'h0000_007e);
        chk("no reset inactive", {31'h0, rst_n_o}, 32'h1);
        // activation set by write, clear ignored
        bus(1'b1, `WDT_CTRL_OFFSET, 32'h0000_00ff, rd, er);
        bus(1'b1, `WDT_CTRL_OFFSET, 32'h0000_007f, rd, er);
        bus(1'b0, `WDT_CTRL_OFFSET, 32'h0, rd, er);
        chk("active sticky", rd, exp_ctrl(1'b1, 8'h7f));
        // random refresh values, wait level toggled alongside
        for (int i = 0; i < 8; i++) begin
            v = 8'hc0 | 8'($urandom() & 32'h3f);
            wait_i <= 1'($urandom());
            bus(1'b1, `WDT_CTRL_OFFSET, {24'h0, v}, rd, er);
            bus(1'b0, `WDT_CTRL_OFFSET, 32'h0, rd, er);
            chk("refresh readback", rd, exp_ctrl(1'b1, v));
        end
        wait_i <= 1'b0;
        chk("no reset refreshed", {31'h0, rst_n_o}, 32'h1);
        // refresh to 40h, then halt without option: frozen, then interrupt wake
        bus(1'b1, `WDT_CTRL_OFFSET, 32'h0000_00c0, rd, er);
        halt_i <= 1'b1;
        idle(1);
        halt_i <= 1'b0;
        idle(4);
        chk("halted", {31'h0, halted_o}, 32'h1);
        bus(1'b0, `WDT_STAT_OFFSET, 32'h0, rd, er);
        chk("status halted", {31'h0, rd[1]}, 32'h1);
        ext_irq_i <= 1'b1;
        idle(1);
        ext_irq_i <= 1'b0;
        idle(4);
        chk("woken", {31'h0, halted_o}, 32'h0);
        bus(1'b0, `WDT_STAT_OFFSET, 32'h0, rd, er);
        chk("wake delay running", {31'h0, rd[0]}, 32'h1);
        bus(1'b0, `WDT_CTRL_OFFSET, 32'h0, rd, er);
        chk("count kept over halt", rd, exp_ctrl(1'b1, 8'hc0));
        // active rollover 40h to 3Fh comes one wake delay late
        idle(49200);
        chk("no reset in wake delay", {31'h0, rst_n_o}, 32'h1);
        for (int i = 0; i < 5000 && rst_n_o !== 1'b0; i++) @(posedge clk_i);
        chk("rollover reset", {31'h0, rst_n_o}, 32'h0);
        // software reset: active with top bit clear
        do_reset();
        bus(1'b1, `WDT_CTRL_OFFSET, 32'h0000_00bf, rd, er);
        for (int i = 0; i < 20 && rst_n_o !== 1'b0; i++) @(posedge clk_i);
        chk("reset started", {31'h0, rst_n_o}, 32'h0);
        n = 0;
        while (rst_n_o === 1'b0 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        chk("reset pulse cycles", n, `WDT_PULSE_CYC);
        // reset-on-halt option: halt while active resets at once
        hr_opt <= 1'b1;
        do_reset();
        bus(1'b1, `WDT_CTRL_OFFSET, 32'h0000_00ff, rd, er);
        halt_i <= 1'b1;
        idle(1);
        halt_i <= 1'b0;
        for (int i = 0; i < 20 && rst_n_o !== 1'b0; i++) @(posedge clk_i);
        chk("halt reset", {31'h0, rst_n_o}, 32'h0);
        chk("no freeze on halt reset", {31'h0, halted_o}, 32'h0);
        // hardware option: active without the bit
        hr_opt <= 1'b0;
        hw_opt <= 1'b1;
        do_reset();
        bus(1'b0, `WDT_STAT_OFFSET, 32'h0, rd, er);
        chk("hardware active", {31'h0, rd[2]}, 32'h1);
        bus(1'b0, `WDT_CTRL_OFFSET, 32'h0, rd, er);
        chk("hardware ctrl", rd, {24'h0, `WDT_CTRL_RESET});
        bus(1'b1, `WDT_CTRL_OFFSET, 32'h0000_003f, rd, er);
        for (int i = 0; i < 20 && rst_n_o !== 1'b0; i++) @(posedge clk_i);
        chk("hardware soft reset", {31'h0, rst_n_o}, 32'h0);
        // system reset returns to the inactive state
        hw_opt <= 1'b0;
        do_reset();
        bus(1'b0, `WDT_CTRL_OFFSET, 32'h0, rd, er);
        chk("ctrl after second reset", rd, 32'h0000_007f);
        chk("pin released", {31'h0, rst_n_o}, 32'h1);
        end_of_test();
    end
endmodule : watchdog_reset_timer_test

// file: wdt_core.sv
// watchdog reset timer top: control register on wishbone, prescaler, down-counter,
// halt handling and reset request
// assumes the option inputs are steady before reset is released and that the cpu
// pulses halt_i when it executes the halt instruction
`timescale 1ns/1ps
`include "wdt_defines.svh"

// Function
// - count decrements every 49,152 clocks, 64 steps
// - active and 40h to 3Fh pulses reset
// - down-counter runs even inactive, stops while halted and in the wake delay
// - inactive after reset, stays active once set
// - active write with top bit clear resets
// - hardware option forces active, ignores bit
// - wait state leaves counting unchanged
// - halt with option and active resets at once
// - halt without option freezes, no rollover resets
// - interrupt wake resumes after 4096 clocks
// - control resets to 7Fh, active then count
// - software sets active, only reset clears it
module wdt_core (
    input  wire logic               clk_i,       // core clock, 50 MHz
    input  wire logic               rst_i,       // synchronous reset, active high
    input  wire wdt_pkg::wdt_wb_req_t wb_req_i,  // wishbone request
    output wdt_pkg::wdt_wb_rsp_t    wb_rsp_o,    // wishbone answer
    input  wire logic               hw_wdt_i,    // hardware watchdog option
    input  wire logic               halt_rst_i,  // reset-on-halt option
    input  wire logic               wait_i,      // cpu in wait state
    input  wire logic               halt_i,      // one-cycle halt instruction
    input  wire logic               ext_irq_i,   // external interrupt wake
    output logic                    rst_n_o,     // reset pin, low active
    output logic                    halted_o     // watchdog frozen by halt
);
    import wdt_pkg::*;

    // all state of the watchdog
    typedef struct packed {
        logic        active;   // watchdog_active
        logic [6:0]  count;    // count_top_bit and delay_steps
        logic [15:0] pre;      // prescaler
        logic        halted;   // oscillator stopped
        logic [12:0] wake;     // wake-up delay left
        logic        hw_opt;   // captured hardware option
        logic        hr_opt;   // captured reset-on-halt option
        logic        fire;     // one-cycle reset request
        logic        fired;    // reset already requested
        wdt_wb_rsp_t rsp;      // bus answer
    } wdt_state_t;

    wdt_state_t cur;       // registered state
    wdt_state_t next_cur;  // next state

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // true when the bus addresses a given register
    function automatic logic hit(input wdt_wb_req_t r, input logic [7:0] off);
        hit = (r.adr[7:2] == off[7:2]);
    endfunction : hit

    logic       req;        // new bus request this cycle
    logic       wr_ctrl;    // accepted write to watchdog_control
    logic       eff_active; // active after options
    logic       counting;   // counter may advance
    logic       step;       // prescaler rolls over
    logic [7:0] wdat;       // written control byte

    always_comb begin
        req        = wb_req_i.cyc && wb_req_i.stb && !cur.rsp.ack && !cur.rsp.err;
        wr_ctrl    = req && wb_req_i.we && wb_req_i.sel[0]
                     && hit(wb_req_i, `WDT_CTRL_OFFSET);
        wdat       = wb_req_i.dat[7:0];
        eff_active = cur.active || cur.hw_opt;
        counting   = !cur.halted && (cur.wake == 13'h0000);
        step       = counting && (cur.pre == `WDT_PRESCALE_LAST);
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_cur          = cur;
        next_cur.fire     = 1'b0;
        next_cur.rsp.ack  = 1'b0;
        next_cur.rsp.err  = 1'b0;
        next_cur.rsp.dat  = `WDT_ZERO32;

        // prescaler and down-counter run whether or not active; wait ignored
        if (counting) begin
            next_cur.pre = step ? 16'h0000 : cur.pre + 16'h0001;
        end
        if (step) begin
            next_cur.count = cur.count - 7'h01;
            if (eff_active && cur.count == 7'h40 && !cur.fired) begin
                next_cur.fire = 1'b1;
            end
        end

        // wake-up delay after an interrupt
        if (cur.wake != 13'h0000) begin
            next_cur.wake = cur.wake - 13'h0001;
        end

        // halt instruction
        if (halt_i && !cur.halted) begin
            if (cur.hr_opt && eff_active) begin
                next_cur.fire = !cur.fired;
            end else if (!cur.hr_opt) begin
                next_cur.halted = 1'b1;
            end
        end
        if (cur.halted && ext_irq_i) begin
            next_cur.halted = 1'b0;
            next_cur.wake   = `WDT_WAKE_CYC;
        end

        // register writes: count loaded, active only ORed in
        if (wr_ctrl) begin
            next_cur.count  = wdat[`WDT_TOP_BIT:0];
            next_cur.active = cur.active | wdat[`WDT_ACTIVE_BIT];
            next_cur.pre    = 16'h0000;
            if ((wdat[`WDT_ACTIVE_BIT] || eff_active) && !wdat[`WDT_TOP_BIT]
                && !cur.fired) begin
                next_cur.fire = 1'b1;
            end
        end
        if (next_cur.fire) begin
            next_cur.fired = 1'b1;
        end

        // bus answers
        if (req) begin
            if (hit(wb_req_i, `WDT_CTRL_OFFSET)) begin
                next_cur.rsp.ack      = 1'b1;
                next_cur.rsp.dat[7:0] = {cur.active, cur.count};
            end else if (hit(wb_req_i, `WDT_STAT_OFFSET) && !wb_req_i.we) begin
                next_cur.rsp.ack      = 1'b1;
                next_cur.rsp.dat[2:0] = {eff_active, cur.halted, cur.wake != 13'h0000};
            end else begin
                next_cur.rsp.err      = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; options caught at the release edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur.active <= 1'b0;
            cur.count  <= 7'(`WDT_CTRL_RESET);
            cur.pre    <= 16'h0000;
            cur.halted <= 1'b0;
            cur.wake   <= 13'h0000;
            cur.hw_opt <= hw_wdt_i;
            cur.hr_opt <= halt_rst_i;
            cur.fire   <= 1'b0;
            cur.fired  <= 1'b0;
            cur.rsp    <= '0;
        end else begin
            cur        <= next_cur;
        end
    end

    // the option bits are caught in the state register while reset holds,
    // so a pin that wiggles later cannot switch the watchdog mode

    ////////////////////////////////////////////////////////////////////////////
    // reset pulse generator
    wdt_pulse u_pulse (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .fire_i  (cur.fire),
        .rst_n_o (rst_n_o)
    );

    assign wb_rsp_o = cur.rsp;
    assign halted_o = cur.halted;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // no second step within 8 cycles of a step
    step_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
        step |=> !step [*8])
        else $error("count stepped too soon");

    // rollover with active raises a reset request next cycle
    roll_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (step && eff_active && cur.count == 7'h40 && !cur.fired && !wr_ctrl)
        |=> cur.fire)
        else $error("rollover gave no reset");

    // counter keeps running while inactive
    free_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (step && !wr_ctrl && !eff_active) |=> cur.count == $past(cur.count) - 7'h01)
        else $error("counter stopped while inactive");

    // active never falls outside reset
    sticky_act_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cur.active |=> cur.active)
        else $error("active bit cleared");

    // write with active and top bit clear resets
    soft_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_ctrl && wdat[`WDT_ACTIVE_BIT] && !wdat[`WDT_TOP_BIT] && !cur.fired)
        |=> cur.fire)
        else $error("software reset missed");

    // halt with option and active resets
    halt_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt_i && !cur.halted && cur.hr_opt && eff_active && !cur.fired) |=> cur.fire)
        else $error("halt reset missed");

    // frozen count while halted
    halt_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cur.halted && !wr_ctrl) |=> (cur.count == $past(cur.count)) && !cur.fire)
        else $error("count moved in halt");

    // wake delay holds counting off
    wake_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cur.halted && ext_irq_i) |=> (cur.wake == `WDT_WAKE_CYC) ##1 !step [*8])
        else $error("wake delay not applied");

    // written count lands at once
    write_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> cur.count == $past(wdat[6:0]))
        else $error("write did not load count");

    // wait level never stalls the prescaler
    wait_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wait_i && counting && !step && !wr_ctrl) |=> cur.pre == $past(cur.pre) + 16'h0001)
        else $error("prescaler stalled in wait");

    // halt without the option freezes the watchdog
    halt_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt_i && !cur.halted && !cur.hr_opt) |=> cur.halted)
        else $error("halt did not freeze");

    // captured options stay put outside reset
    opt_static_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (cur.hw_opt == $past(cur.hw_opt)) && (cur.hr_opt == $past(cur.hr_opt)))
        else $error("option bits changed");

    // every accepted request gets one answer
    bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> (cur.rsp.ack || cur.rsp.err))
        else $error("bus request unanswered");

    // acknowledge lasts a single cycle
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cur.rsp.ack |=> !cur.rsp.ack)
        else $error("acknowledge held too long");

endmodule : wdt_core

// file: wdt_defines.svh
// constants of the watchdog reset timer: register map, reset values, timing counts
// assumes a 50 MHz core clock and a wishbone register bus with 32-bit data
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

`define WDT_CTRL_OFFSET     8'h0c          // byte offset of watchdog_control
`define WDT_CTRL_RESET      8'h7f          // watchdog_control after reset
`define WDT_STAT_OFFSET     8'h10          // byte offset of the status register
`define WDT_ACTIVE_BIT      7              // watchdog_active position
`define WDT_TOP_BIT         6              // count_top_bit position
`define WDT_PRESCALE        16'd49152      // cpu clocks per count step
`define WDT_PRESCALE_LAST   16'd49151      // last prescaler value before a step
`define WDT_PULSE_NS        30000          // reset pulse length in ns
`define WDT_CLK_NS          20             // clock period in ns
`define WDT_PULSE_CYC       (`WDT_PULSE_NS / `WDT_CLK_NS)  // reset pulse cycles
`define WDT_WAKE_CYC        13'd4096       // cpu clocks before counting after wake
`define WDT_ZERO32          32'h0000_0000  // read data filler

`endif

// file: wdt_pkg.sv
// types of the watchdog reset timer
// assumes wdt_defines.svh is compiled alongside
package wdt_pkg;

    // wishbone request from the master
    typedef struct packed {
        logic        cyc;   // cycle valid
        logic        stb;   // strobe
        logic        we;    // write enable
        logic [7:0]  adr;   // byte address
        logic [3:0]  sel;   // byte lanes
        logic [31:0] dat;   // write data
    } wdt_wb_req_t;

    // wishbone answer to the master
    typedef struct packed {
        logic        ack;   // acknowledge
        logic        err;   // error for unmapped address or status write
        logic [31:0] dat;   // read data
    } wdt_wb_rsp_t;

    // states of the reset pulse generator
    typedef enum logic [1:0] {
        WDT_P_IDLE = 2'b00, // no reset pending
        WDT_P_LOW  = 2'b01, // reset pin held low
        WDT_P_DONE = 2'b10  // waiting for system reset
    } wdt_pulse_st_t;

endpackage : wdt_pkg

// file: wdt_pulse.sv
// reset pulse generator: stretches a one-cycle trigger into a low-going reset
// assumes the system reset follows from the pulse and re-arms this block
`timescale 1ns/1ps
`include "wdt_defines.svh"

module wdt_pulse (
    input  wire logic clk_i,   // core clock
    input  wire logic rst_i,   // synchronous reset, active high
    input  wire logic fire_i,  // one-cycle reset request
    output logic      rst_n_o  // reset pin level, low while resetting
);
    import wdt_pkg::*;

    // all state of the pulse generator
    typedef struct packed {
        wdt_pulse_st_t st;   // pulse state
        logic [10:0]   cnt;  // cycles left in the pulse
        logic          pin;  // registered pin level
    } wdt_pulse_state_t;

    wdt_pulse_state_t cur;       // registered state
    wdt_pulse_state_t next_cur;  // next state

    ////////////////////////////////////////////////////////////////////////////
    // next state: trigger starts a pulse of the fixed length
    always_comb begin
        next_cur = cur;
        case (cur.st)
            WDT_P_IDLE: begin
                if (fire_i) begin
                    next_cur.st  = WDT_P_LOW;
                    next_cur.cnt = 11'(`WDT_PULSE_CYC - 1);
                    next_cur.pin = 1'b0;
                end
            end
            WDT_P_LOW: begin
                if (cur.cnt == 11'h000) begin
                    next_cur.st  = WDT_P_DONE;
                    next_cur.pin = 1'b1;
                end else begin
                    next_cur.cnt = cur.cnt - 11'h001;
                end
            end
            WDT_P_DONE: begin
                next_cur.pin = 1'b1;  // held high until the system resets us
            end
            default: begin
                next_cur.st = WDT_P_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur.st  <= WDT_P_IDLE;
            cur.cnt <= 11'h000;
            cur.pin <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign rst_n_o = cur.pin;

    // pulse holds the pin low for at least 8 cycles once fired
    pulse_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cur.st == WDT_P_IDLE && fire_i) |=> !rst_n_o [*8])
        else $error("reset pulse too short");

endmodule : wdt_pulse
